// ==== svd_ctrl.sv ====
// Supply voltage detector control: settings, sampling, flag and reset.
`default_nettype none
module supply_voltage_detector_ctrl (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Software write port
	input wire logic [15:0] i_protect_key,
	input wire logic i_ctrl_we,
	input wire svd_pkg::control_type i_ctrl,
	input wire logic i_clock_we,
	input wire logic i_debug_run,
	input wire logic [1:0] i_clock_source_select,
	input wire logic [2:0] i_clock_divider_select,
	input wire logic i_irq_enable_we,
	input wire logic i_low_voltage_irq_enable,
	input wire logic i_flag_clear,
	// Power state
	input wire logic i_sleep,
	input wire logic i_sleep_clock_stop,
	input wire logic i_debug,
	// Comparator
	input wire logic i_below_threshold,
	output logic o_comparator_power,
	output logic o_supply_source_select,
	output logic [4:0] o_threshold_level_select,
	// Status and events
	output svd_pkg::control_type o_ctrl,
	output logic o_debug_run,
	output logic [1:0] o_clock_source_select,
	output logic [2:0] o_clock_divider_select,
	output logic o_low_voltage_irq_enable,
	output logic o_low_voltage_status,
	output logic o_low_voltage_flag,
	output logic o_irq,
	output logic o_system_reset
);
	import svd_pkg::*;

	control_type ctrl_q;
	logic debug_run_q;
	logic [1:0] clk_src_q;
	logic [2:0] clk_div_q;
	logic irq_en_q;
	logic status_q;
	logic flag_q;
	logic reset_q;
	logic power_q;
	logic [3:0] low_cnt_q;
	logic unlocked;
	logic run;
	logic continuous;
	logic samp_power;
	logic samp_strobe;
	logic low_event;
	logic [3:0] need;

	// ****************************************
	// Protection and run gating
	// ****************************************
	assign unlocked = (i_protect_key == PROTECT_KEY_OPEN);
	assign run = ctrl_q.detector_enable
		&& !(i_sleep && i_sleep_clock_stop)
		&& !(i_debug && !debug_run_q);
	assign continuous = (ctrl_q.sampling_interval_mode == MODE_CONTINUOUS);
	assign need = low_count_need(ctrl_q.low_count_select);

	svd_sampler u_sampler (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_run(run),
		.i_continuous(continuous),
		.i_mode(ctrl_q.sampling_interval_mode),
		.o_power(samp_power),
		.o_sample(samp_strobe)
	);

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ctrl_q <= '{1'b0, 2'h0, THRESHOLD_RESET, 4'h0, MODE_CONTINUOUS, 1'b0};
		end else if (low_event && ctrl_q.reset_enable_key == RESET_KEY_ON) begin
			ctrl_q.sampling_interval_mode <= MODE_CONTINUOUS;
			ctrl_q.low_count_select <= 2'h0;
		end else if (i_ctrl_we && unlocked && !reset_q) begin
			ctrl_q <= i_ctrl;
			if (i_ctrl.threshold_level_select > THRESHOLD_MAX) begin
				ctrl_q.threshold_level_select <= THRESHOLD_MAX;
			end
			if (i_ctrl.sampling_interval_mode == MODE_CONTINUOUS) begin
				ctrl_q.low_count_select <= ctrl_q.low_count_select;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b || reset_q) begin
			debug_run_q <= 1'b1;
			clk_src_q <= 2'h0;
			clk_div_q <= 3'h0;
		end else if (i_clock_we && unlocked) begin
			debug_run_q <= i_debug_run;
			clk_src_q <= i_clock_source_select;
			clk_div_q <= i_clock_divider_select;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b || reset_q) begin
			irq_en_q <= 1'b0;
		end else if (i_irq_enable_we) begin
			irq_en_q <= i_low_voltage_irq_enable;
		end
	end

	// ****************************************
	// Detection and counting
	// ****************************************
	// The comparator answers only after a cycle of power, so a cold result is never taken as status.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			status_q <= 1'b0;
		end else if (run && (continuous ? power_q : samp_strobe)) begin
			status_q <= i_below_threshold;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b || !ctrl_q.detector_enable || continuous) begin
			low_cnt_q <= 4'h0;
		end else if (run && samp_strobe) begin
			if (!i_below_threshold) begin
				low_cnt_q <= 4'h0;
			end else if (low_cnt_q < need) begin
				low_cnt_q <= low_cnt_q + 4'h1;
			end
		end
	end

	// A low event fires once the status or count condition holds.
	assign low_event = run && (continuous ? status_q
		: (low_cnt_q >= need));

	// ****************************************
	// Flag, interrupt and reset
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			flag_q <= 1'b0;
		end else if (low_event) begin
			flag_q <= 1'b1;
		end else if (i_flag_clear && !reset_q) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			reset_q <= 1'b0;
		end else if (low_event && ctrl_q.reset_enable_key == RESET_KEY_ON) begin
			reset_q <= 1'b1;
		end else if (reset_q && !status_q && continuous) begin
			reset_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			power_q <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			power_q <= run && (continuous || samp_power);
			o_irq <= flag_q && irq_en_q && ctrl_q.reset_enable_key != RESET_KEY_ON;
		end
	end

	always_comb begin
		o_comparator_power = power_q;
		o_supply_source_select = ctrl_q.supply_source_select;
		o_threshold_level_select = ctrl_q.threshold_level_select;
		o_ctrl = ctrl_q;
		o_debug_run = debug_run_q;
		o_clock_source_select = clk_src_q;
		o_clock_divider_select = clk_div_q;
		o_low_voltage_irq_enable = irq_en_q;
		o_low_voltage_status = status_q;
		o_low_voltage_flag = flag_q;
		o_system_reset = reset_q;
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence low_seen;
		low_event;
	endsequence

	AST_FLAG_SETS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		low_seen |=> o_low_voltage_flag) else $error("flag not set after low event");
	AST_FLAG_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_low_voltage_flag && !i_flag_clear |=> o_low_voltage_flag) else $error("flag dropped");
	AST_IRQ_GATED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_irq |-> $past(flag_q) && $past(irq_en_q)) else $error("irq without flag and enable");
	AST_RESET_KEY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$rose(o_system_reset) |-> $past(ctrl_q.reset_enable_key) == RESET_KEY_ON) else $error("bad reset");
	AST_RESET_CONT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_system_reset |-> continuous) else $error("reset outside continuous mode");
	AST_LOCKED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_ctrl_we && !unlocked && !low_event |=> $stable(ctrl_q)) else $error("write while protected");
	AST_DISABLED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!ctrl_q.detector_enable |=> !power_q) else $error("power while disabled");
	AST_CNT_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		run && samp_strobe && !i_below_threshold && !continuous |=> low_cnt_q == 4'h0) else $error("count kept");
	AST_CONT_STATUS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		run && continuous && power_q |=> o_low_voltage_status == $past(i_below_threshold)) else $error("status stale");

	sequence halted;
		ctrl_q.detector_enable && !run;
	endsequence

	AST_HALT_KEEPS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		halted |=> !power_q && $stable(status_q)) else $error("detector ran while halted");
	AST_COLD_SAMPLE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		run && continuous && !power_q |=> $stable(status_q)) else $error("status taken unpowered");
	AST_STROBE_POWERED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		run && samp_strobe |-> power_q) else $error("sample strobe without comparator power");
	AST_THRESH_RANGE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_threshold_level_select <= THRESHOLD_MAX) else $error("threshold out of range");
	AST_RESET_CLEARS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_system_reset |=> !o_low_voltage_irq_enable && o_debug_run) else $error("settings kept during reset");
endmodule
`default_nettype wire

// ==== svd_pkg.sv ====
// Package for the supply voltage detector control block.
`default_nettype none
package svd_pkg;
	localparam logic [15:0] PROTECT_KEY_OPEN = 16'h0096;
	localparam logic [3:0] RESET_KEY_ON = 4'ha;
	localparam logic [4:0] THRESHOLD_RESET = 5'h1e;
	localparam logic [4:0] THRESHOLD_MAX = 5'h1e;
	localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
	localparam logic [8:0] INTERVAL_1 = 9'h03f;
	localparam logic [8:0] INTERVAL_2 = 9'h0ff;
	localparam logic [8:0] INTERVAL_3 = 9'h1ff;
	localparam logic [2:0] SETTLE_CYCLES = 3'h3;

	typedef struct packed {
		logic supply_source_select;
		logic [1:0] low_count_select;
		logic [4:0] threshold_level_select;
		logic [3:0] reset_enable_key;
		logic [1:0] sampling_interval_mode;
		logic detector_enable;
	} control_type;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_WAIT = 2'b01,
		ST_SETTLE = 2'b10,
		ST_SAMPLE = 2'b11
	} sample_state_type;

	function automatic logic [3:0] low_count_need(input logic [1:0] code);
		case (code)
			2'h0: low_count_need = 4'h1;
			2'h1: low_count_need = 4'h2;
			2'h2: low_count_need = 4'h4;
			default: low_count_need = 4'h8;
		endcase
	endfunction

	function automatic logic [8:0] interval_of(input logic [1:0] mode);
		case (mode)
			2'h1: interval_of = INTERVAL_1;
			2'h2: interval_of = INTERVAL_2;
			default: interval_of = INTERVAL_3;
		endcase
	endfunction
endpackage
`default_nettype wire

// ==== svd_sampler.sv ====
// Interval timer that powers the comparator and strobes one sample.
`default_nettype none
module svd_sampler (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Control
	input wire logic i_run,
	input wire logic i_continuous,
	input wire logic [1:0] i_mode,
	// Comparator side
	output logic o_power,
	output logic o_sample
);
	import svd_pkg::*;

	sample_state_type state_q;
	logic [8:0] timer_q;
	logic [2:0] settle_q;

	// ****************************************
	// Sampling sequencer
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_b || !i_run || i_continuous) begin
			state_q <= ST_OFF;
			timer_q <= 9'h000;
			settle_q <= 3'h0;
		end else begin
			case (state_q)
				ST_OFF: begin
					state_q <= ST_WAIT;
					timer_q <= interval_of(i_mode);
				end
				ST_WAIT: begin
					if (timer_q == 9'h000) begin
						state_q <= ST_SETTLE;
						settle_q <= SETTLE_CYCLES;
					end else begin
						timer_q <= timer_q - 9'h001;
					end
				end
				ST_SETTLE: begin
					if (settle_q == 3'h0) begin
						state_q <= ST_SAMPLE;
					end else begin
						settle_q <= settle_q - 3'h1;
					end
				end
				ST_SAMPLE: begin
					state_q <= ST_WAIT;
					timer_q <= interval_of(i_mode);
				end
				default: state_q <= ST_OFF;
			endcase
		end
	end

	always_comb begin
		o_power = (state_q == ST_SETTLE) || (state_q == ST_SAMPLE);
		o_sample = (state_q == ST_SAMPLE);
	end
endmodule
`default_nettype wire

// ==== svd_comparator_model.sv ====
// Behavioural analog comparator on the far side of the detector.
`default_nettype none
module svd_comparator_model (
	// Clock
	input wire logic i_clk,
	// Detector side
	input wire logic i_power,
	input wire logic i_source,
	input wire logic [4:0] i_threshold,
	// Supply levels in threshold steps
	input wire logic [4:0] i_core_level,
	input wire logic [4:0] i_ext_level,
	output logic o_below
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_q = 1'b0;
	// An unpowered comparator gives no valid answer, so its output wanders every cycle.
	always_ff @(posedge i_clk) begin
		last_q <= o_below;
	end
	always_comb begin
		if (i_power) begin
			o_below = ((i_source ? i_ext_level : i_core_level) < i_threshold);
		end else begin
			o_below = ~last_q;
		end
	end
endmodule
`default_nettype wire

// ==== tb_supply_voltage_detector_ctrl.sv ====
// Self-checking testbench of the supply voltage detector control.
`default_nettype none
module tb_supply_voltage_detector_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import svd_pkg::*;
	// ****************
	// Bench signals
	// ****************
	logic i_clk = 1'b0, i_rst_b = 1'b0, cwe = 1'b0, kwe = 1'b0, iwe = 1'b0, ie = 1'b0, fclr = 1'b0;
	logic drun = 1'b0, slp = 1'b0, sstop = 1'b0, dbg = 1'b0, pwr, below, st, flag, irq, srst, o_drun, o_ie, o_src;
	logic [15:0] key = 16'h0000;
	logic [1:0] csrc = 2'h0, o_csrc;
	logic [2:0] cdiv = 3'h0, o_cdiv;
	logic [4:0] core = 5'h1f, ext = 5'h1f, thr, t;
	logic [31:0] rng = 32'd54679;
	control_type ctl = '0, c, o_ctl;
	int miscompares = 0, n_compared = 0, cycles = 0, n;
	int exp_q[$];
	supply_voltage_detector_ctrl DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_protect_key(key),
		.i_ctrl_we(cwe), .i_ctrl(ctl), .i_clock_we(kwe), .i_debug_run(drun),
		.i_clock_source_select(csrc), .i_clock_divider_select(cdiv), .i_irq_enable_we(iwe),
		.i_low_voltage_irq_enable(ie), .i_flag_clear(fclr), .i_sleep(slp), .i_sleep_clock_stop(sstop),
		.i_debug(dbg), .i_below_threshold(below), .o_comparator_power(pwr), .o_supply_source_select(o_src),
		.o_threshold_level_select(thr), .o_ctrl(o_ctl), .o_debug_run(o_drun), .o_clock_source_select(o_csrc),
		.o_clock_divider_select(o_cdiv), .o_low_voltage_irq_enable(o_ie), .o_low_voltage_status(st),
		.o_low_voltage_flag(flag), .o_irq(irq), .o_system_reset(srst));
	svd_comparator_model cmp (.i_clk(i_clk), .i_power(pwr), .i_source(o_src), .i_threshold(thr),
		.i_core_level(core), .i_ext_level(ext), .o_below(below));
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end
	// The ceiling leaves room for fifteen slow samples and the reset episode.
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge i_clk);
	endtask
	task automatic wr(input logic [15:0] k, input control_type v);
		@(negedge i_clk);
		key = k;
		ctl = v;
		cwe = 1'b1;
		@(negedge i_clk);
		cwe = 1'b0;
	endtask
	task automatic pulse_clr();
		@(negedge i_clk);
		fclr = 1'b1;
		@(negedge i_clk);
		fclr = 1'b0;
	endtask
	task automatic set_ie(input logic v);
		@(negedge i_clk);
		ie = v;
		iwe = 1'b1;
		@(negedge i_clk);
		iwe = 1'b0;
	endtask
	// Counts comparator power-ups until the flag or the reset appears.
	task automatic wait_event(output int rises);
		logic p;
		rises = 0;
		p = pwr;
		for (int i = 0; i < 1500 && flag !== 1'b1 && srst !== 1'b1; i++) begin
			@(negedge i_clk);
			if (pwr && !p) rises++;
			p = pwr;
		end
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		cyc(16);
		i_rst_b = 1'b1;
		cyc(1);
		chk(thr, 16'h1e);
		chk({o_drun, flag, srst, o_ctl.detector_enable}, 16'h8);
		rng = xs(rng);
		t = 5'(rng[7:0] % 29 + 1);
		c = '0;
		c.threshold_level_select = t;
		wr(16'h0095, c);
		@(negedge i_clk);
		key = 16'h0096;
		{csrc, cdiv} = rng[12:8];
		kwe = 1'b1;
		cyc(1);
		kwe = 1'b0;
		cyc(1);
		chk(thr, 16'h1e);
		chk({o_drun, o_csrc, o_cdiv}, {10'h0, 1'b0, rng[12:8]});
		pulse_clr();
		set_ie(1'b1);
		core = t;
		ext = 5'h0;
		c.detector_enable = 1'b1;
		wr(16'h0096, c);
		cyc(4);
		chk({st, flag}, 16'h0);
		core = t - 5'h1;
		cyc(4);
		chk({st, flag, irq}, 16'h7);
		core = t;
		cyc(4);
		chk({st, flag, irq}, 16'h3);
		set_ie(1'b0);
		cyc(1);
		chk(irq, 16'h0);
		pulse_clr();
		cyc(2);
		chk(flag, 16'h0);
		c.supply_source_select = 1'b1;
		wr(16'h0096, c);
		cyc(4);
		chk({o_src, st}, 16'h3);
		dbg = 1'b1;
		ext = 5'h1f;
		cyc(4);
		chk({pwr, st}, 16'h1);
		dbg = 1'b0;
		cyc(4);
		chk({pwr, st}, 16'h2);
		slp = 1'b1;
		sstop = 1'b1;
		ext = 5'h0;
		cyc(4);
		chk({pwr, st}, 16'h0);
		slp = 1'b0;
		cyc(4);
		chk({pwr, st}, 16'h3);
		c.threshold_level_select = 5'h1f;
		ext = 5'h1e;
		wr(16'h0096, c);
		cyc(4);
		chk({thr, st}, 16'h3c);
		c.detector_enable = 1'b0;
		wr(16'h0096, c);
		cyc(1);
		chk(pwr, 16'h0);
		ext = 5'h1f;
		pulse_clr();
		set_ie(1'b1);
		c = '0;
		c.threshold_level_select = t;
		c.reset_enable_key = RESET_KEY_ON;
		c.sampling_interval_mode = 2'h1;
		c.detector_enable = 1'b1;
		core = 5'h0;
		wr(16'h0096, c);
		wait_event(n);
		cyc(2);
		chk({srst, irq, o_ie, o_drun}, 16'h9);
		wr(16'h0096, '0);
		core = 5'h1f;
		for (int i = 0; i < 20 && srst !== 1'b0; i++) cyc(1);
		cyc(2);
		chk({srst, o_ctl.detector_enable, o_ctl.sampling_interval_mode}, 16'h4);
		wr(16'h0096, '0);
		for (int code = 0; code < 4; code++) begin
			pulse_clr();
			c.reset_enable_key = 4'h0;
			c.low_count_select = 2'(code);
			c.sampling_interval_mode = (code < 2) ? 2'(3 - code) : 2'h1;
			core = 5'h0;
			exp_q.push_back(1 << code);
			wr(16'h0096, c);
			wait_event(n);
			chk(16'(n), 16'(exp_q.pop_front()));
			chk({pwr, st}, 16'h1);
			wr(16'h0096, '0);
		end
		test_done();
	end
endmodule
`default_nettype wire
